// ---- design/ext_cfg_pkg.sv ----
package ext_cfg_pkg;

    // ------------------------------------------------------------
    // port addresses and index space
    // ------------------------------------------------------------
    localparam logic [15:0] INDEX_PORT_ADDR   = 16'h03D6;
    localparam logic [15:0] DATA_PORT_ADDR    = 16'h03D7;
    localparam int          INDEX_W           = 7;
    localparam int          DATA_W            = 8;
    localparam int          REG_COUNT         = 128;

    localparam logic [6:0]  IDX_CHIP_VERSION  = 7'h00;
    localparam logic [6:0]  IDX_STRAP_LOW     = 7'h01;
    localparam logic [6:0]  IDX_HOST_CTRL_A   = 7'h02;
    localparam logic [6:0]  IDX_HOST_CTRL_B   = 7'h03;
    localparam logic [6:0]  IDX_MEM_CTRL_A    = 7'h04;
    localparam logic [6:0]  IDX_WIDE_IO_BASE  = 7'h07;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STRAP_BUS_LSB      = 0;
    localparam int STRAP_ISA_HALF     = 3;
    localparam int STRAP_CLK_INTERNAL = 4;
    localparam int STRAP_LDEV_DECODE  = 6;
    localparam int STRAP_CACHE_RDY    = 7;
    localparam int CTRLA_ATTR_LSB     = 3;
    localparam int CTRLA_DECODE10     = 5;
    localparam int CTRLA_ATTR_FF      = 7;
    localparam int CTRLB_PAL_SHADOW   = 0;
    localparam int CTRLB_WIDE_EN      = 1;
    localparam int MEMA_CFG_LSB       = 0;
    localparam int MEMA_BIT17_EN      = 2;
    localparam int MEMA_MCS16_COMPAT  = 3;
    localparam int MEMA_FIFO_EN       = 5;
    localparam int MEMA_ZWS_EN        = 6;

    // ------------------------------------------------------------
    // write masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRLA_WR_MASK  = 8'h38;
    localparam logic [7:0] CTRLB_WR_MASK  = 8'h03;
    localparam logic [7:0] MEMA_WR_MASK   = 8'h6F;
    localparam logic [7:0] CTRL_RST_VAL   = 8'h00;
    localparam logic [7:0] IO_BASE_RST    = 8'hF4;
    localparam logic [1:0] BUS_ISA16      = 2'b00;
    localparam logic [1:0] BUS_LOCAL32    = 2'b11;
    localparam logic [6:0] COMPAT_LA_HIT  = 7'h05;
    localparam logic [1:0] MAP_A0_AF      = 2'b01;
    localparam logic [1:0] MAP_B0_B7      = 2'b10;
    localparam logic [1:0] MAP_B8_BF      = 2'b11;

    // indices backed by plain storage, beyond the first five
    function automatic logic is_stored(input logic [6:0] idx);
        unique case (idx)
            7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C,
            7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h14, 7'h15, 7'h16,
            7'h17, 7'h19, 7'h28, 7'h2B, 7'h30, 7'h31, 7'h32, 7'h33,
            7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F, 7'h40, 7'h44,
            7'h52, 7'h70, 7'h71, 7'h72, 7'h73, 7'h74, 7'h75, 7'h7D,
            7'h7F: is_stored = 1'b1;
            default: is_stored = 1'b0;
        endcase
    endfunction : is_stored

    // stored entries that reset to a fixed value; others keep theirs
    function automatic logic has_reset(input logic [6:0] idx);
        unique case (idx)
            7'h05, 7'h06, 7'h07, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E,
            7'h14, 7'h15, 7'h16, 7'h28, 7'h52, 7'h71, 7'h7D,
            7'h7F: has_reset = 1'b1;
            default: has_reset = 1'b0;
        endcase
    endfunction : has_reset

endpackage : ext_cfg_pkg

// ---- design/ext_reg_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

module ext_reg_mem #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int W     = 8
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read side
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [W-1:0]  rd_data_q
);

    logic [W-1:0] mem_q [DEPTH];

    // ------------------------------------------------------------
    // one flop row per entry so that reset can be selective
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        localparam logic [AW-1:0] IDX = AW'(i);
        localparam logic          RST_EN = ext_cfg_pkg::has_reset(IDX);
        localparam logic [W-1:0]  RST_VAL = (IDX == ext_cfg_pkg::IDX_WIDE_IO_BASE) ?
                                            ext_cfg_pkg::IO_BASE_RST :
                                            ext_cfg_pkg::CTRL_RST_VAL;
        always_ff @(posedge clk) begin
            if (rst && RST_EN) begin
                mem_q[i] <= RST_VAL;
            end else if (wr_en && wr_addr == IDX) begin
                mem_q[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        rd_data_q <= mem_q[rd_addr];
    end

endmodule : ext_reg_mem

`default_nettype wire

// ---- design/extension_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// - index port bits 6-0 pick the register; bit 7 reads zero
// - on reset release straps load, fixed fields reset, others keep, missing read zero
// - version low nibble is the silicon revision, counting from zero
// - version high nibble is a fixed chip-type code
// - strap register is read-only, caught at reset, steers logic after
// - strap bits 1-0: 00 ISA 16-bit, 11 local 32-bit, others reserved
// - ISA with internal host clock: strap 3 picks full or half memory clock
// - strap bit 4 picks external or internal clock source
// - strap 6 picks open-collector first-T2 or full-decode LDEV drive
// - local bus: strap 7 low delays RDY by one host clock
// - ISA: strap 7 picks external LCLK or internally made host clock
// - interface bits 4-3 map the attribute port; 01 holds flip-flop reset
// - interface bit 5 set decodes legacy ports on ten address bits
// - interface bit 7 reads the attribute flip-flop state
// - palette shadow runs palette writes but does not claim with LDEV
// - second interface bit 1 enables wide accelerator registers, cleared at reset
// - memory control bit 5 enables the write FIFO, off by default
// - memory control bit 6 enables zero wait states, ISA only
// - memory control bits 1-0 select memory path and size
// - memory control bit 2 enables address counter bit 17, cleared at reset
// - MCS16 decode: bit 3 low whole A0000-BFFFF, high map window only
// - MCS16 always asserted inside linear frame buffer range
module extension_config_regs #(
    parameter logic [3:0] CHIP_TYPE = 4'h6,  // arbitrary value
    parameter logic [3:0] CHIP_REV  = 4'h0
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // host i/o port
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output var  logic [7:0]  io_rdata,
    output var  logic        io_rvalid,
    // strap pins
    input  wire logic [7:0]  strap_bus_bits,
    // bus cycle state from host interface logic
    input  wire logic        attr_ff_is_data,
    input  wire logic        cycle_valid,
    input  wire logic        cycle_first_t2,
    input  wire logic        cycle_palette_wr,
    input  wire logic        linear_fb_hit,
    input  wire logic [6:0]  la_hi,
    input  wire logic [1:0]  sa_mid,
    input  wire logic [1:0]  graphics_misc_map,
    // strap-derived controls
    output var  logic        host_is_local,
    output var  logic        isa_hclk_half,
    output var  logic        clk_src_internal,
    output var  logic        isa_hclk_internal,
    output var  logic        rdy_hold_off,
    // interface controls
    output var  logic [1:0]  attr_map,
    output var  logic        attr_ff_hold_reset,
    output var  logic        decode_low10,
    output var  logic        wide_regs_en,
    output var  logic        palette_wr_exec,
    // memory controls
    output var  logic [1:0]  mem_config,
    output var  logic        addr_bit17_en,
    output var  logic        cpu_fifo_en,
    output var  logic        zws_en,
    // bus claim pins
    output var  logic        ldev_n_out,
    output var  logic        ldev_n_oe,
    output var  logic        mcs16_n
);

    // ------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------
    logic [6:0] index_q;
    logic [7:0] strap_q;
    logic [7:0] ctrl_a_q;
    logic       pal_shadow_q;
    logic       wide_en_q;
    logic [7:0] mem_a_q;
    logic [7:0] strap_s1_q;
    logic [7:0] strap_s2_q;
    logic       strap_pend_q;
    logic [7:0] loc_rdata_q;
    logic       sel_mem_q;
    logic       rd_p1_q;
    logic [7:0] mem_rdata;

    wire hit_index = (io_addr == ext_cfg_pkg::INDEX_PORT_ADDR);
    wire hit_data  = (io_addr == ext_cfg_pkg::DATA_PORT_ADDR);
    wire wr_index  = io_wr && hit_index;
    wire wr_data   = io_wr && hit_data;
    wire is_stored = ext_cfg_pkg::is_stored(index_q);
    wire wr_ctrl_a = wr_data && index_q == ext_cfg_pkg::IDX_HOST_CTRL_A;
    wire wr_ctrl_b = wr_data && index_q == ext_cfg_pkg::IDX_HOST_CTRL_B;
    wire wr_mem_a  = wr_data && index_q == ext_cfg_pkg::IDX_MEM_CTRL_A;
    wire wr_store  = wr_data && is_stored;

    // ------------------------------------------------------------
    // index register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wr_index) begin
            index_q <= io_wdata[6:0];
        end
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // pins are asynchronous to clk, so two flops before any use
    always_ff @(posedge clk) begin
        strap_s1_q <= strap_bus_bits;
        strap_s2_q <= strap_s1_q;
    end

    // caught on the first edge after release, the falling reset
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_pend_q <= 1'b1;
        end else begin
            strap_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst && strap_pend_q) begin
            strap_q <= strap_s2_q;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    wire [7:0] ctrl_a_d = (ctrl_a_q & ~ext_cfg_pkg::CTRLA_WR_MASK) |
                          (io_wdata & ext_cfg_pkg::CTRLA_WR_MASK);
    wire [7:0] mem_a_d  = (mem_a_q & ~ext_cfg_pkg::MEMA_WR_MASK) |
                          (io_wdata & ext_cfg_pkg::MEMA_WR_MASK);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_a_q <= ext_cfg_pkg::CTRL_RST_VAL;
            mem_a_q  <= ext_cfg_pkg::CTRL_RST_VAL;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a_q <= ctrl_a_d;
            end
            if (wr_mem_a) begin
                mem_a_q <= mem_a_d;
            end
        end
    end

    // shadow bit keeps its value over reset; wide enable clears
    always_ff @(posedge clk) begin
        if (rst) begin
            wide_en_q <= 1'b0;
        end else if (wr_ctrl_b) begin
            wide_en_q <= io_wdata[ext_cfg_pkg::CTRLB_WIDE_EN];
        end
    end

    always_ff @(posedge clk) begin
        if (wr_ctrl_b) begin
            pal_shadow_q <= io_wdata[ext_cfg_pkg::CTRLB_PAL_SHADOW];
        end
    end

    wire [7:0] ctrl_b_rd = {6'h00, wide_en_q, pal_shadow_q};

    // ------------------------------------------------------------
    // storage for the remaining registers
    // ------------------------------------------------------------
    ext_reg_mem #(
        .DEPTH (ext_cfg_pkg::REG_COUNT),
        .AW    (ext_cfg_pkg::INDEX_W),
        .W     (ext_cfg_pkg::DATA_W)
    ) u_mem (
        .clk       (clk),
        .rst       (rst),
        .wr_en     (wr_store),
        .wr_addr   (index_q),
        .wr_data   (io_wdata),
        .rd_addr   (index_q),
        .rd_data_q (mem_rdata)
    );

    // ------------------------------------------------------------
    // read path: two cycles, local fields and storage aligned
    // ------------------------------------------------------------
    wire [7:0] version_rd = {CHIP_TYPE, CHIP_REV};
    wire [7:0] ctrl_a_rd  = {attr_ff_is_data, 1'b0, ctrl_a_q[5:3], 3'h0};
    wire [7:0] index_rd   = {1'b0, index_q};
    wire       idx_ver    = index_q == ext_cfg_pkg::IDX_CHIP_VERSION;
    wire       idx_strap  = index_q == ext_cfg_pkg::IDX_STRAP_LOW;
    wire       idx_ctrl_a = index_q == ext_cfg_pkg::IDX_HOST_CTRL_A;
    wire       idx_ctrl_b = index_q == ext_cfg_pkg::IDX_HOST_CTRL_B;
    wire       idx_mem_a  = index_q == ext_cfg_pkg::IDX_MEM_CTRL_A;
    wire [7:0] data_rd    = idx_ver    ? version_rd :
                            idx_strap  ? strap_q    :
                            idx_ctrl_a ? ctrl_a_rd  :
                            idx_ctrl_b ? ctrl_b_rd  :
                            idx_mem_a  ? (mem_a_q & ext_cfg_pkg::MEMA_WR_MASK) :
                            8'h00;
    wire [7:0] loc_rd     = hit_index ? index_rd : data_rd;
    wire       rd_mem     = io_rd && hit_data && is_stored;

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_p1_q   <= 1'b0;
            sel_mem_q <= 1'b0;
            io_rvalid <= 1'b0;
            io_rdata  <= 8'h00;
        end else begin
            rd_p1_q   <= io_rd && (hit_index || hit_data);
            sel_mem_q <= rd_mem;
            io_rvalid <= rd_p1_q;
            io_rdata  <= sel_mem_q ? mem_rdata : loc_rdata_q;
        end
    end

    always_ff @(posedge clk) begin
        loc_rdata_q <= loc_rd;
    end

    // ------------------------------------------------------------
    // strap-driven controls
    // ------------------------------------------------------------
    wire [1:0] bus_type = strap_q[1:0];
    wire       isa_bus  = bus_type == ext_cfg_pkg::BUS_ISA16;
    wire       loc_bus  = bus_type == ext_cfg_pkg::BUS_LOCAL32;

    always_ff @(posedge clk) begin
        if (rst) begin
            host_is_local     <= 1'b0;
            isa_hclk_half     <= 1'b0;
            clk_src_internal  <= 1'b0;
            isa_hclk_internal <= 1'b0;
            rdy_hold_off      <= 1'b0;
        end else begin
            host_is_local     <= loc_bus;
            isa_hclk_half     <= isa_bus && strap_q[7] && strap_q[3];
            clk_src_internal  <= strap_q[ext_cfg_pkg::STRAP_CLK_INTERNAL];
            isa_hclk_internal <= isa_bus && strap_q[7];
            rdy_hold_off      <= loc_bus && !strap_q[7];
        end
    end

    // ------------------------------------------------------------
    // interface and memory controls
    // ------------------------------------------------------------
    assign attr_map      = ctrl_a_q[4:3];
    assign decode_low10  = ctrl_a_q[ext_cfg_pkg::CTRLA_DECODE10];
    assign wide_regs_en  = wide_en_q;
    assign mem_config    = mem_a_q[1:0];
    assign addr_bit17_en = mem_a_q[ext_cfg_pkg::MEMA_BIT17_EN];
    assign cpu_fifo_en   = mem_a_q[ext_cfg_pkg::MEMA_FIFO_EN];

    always_ff @(posedge clk) begin
        if (rst) begin
            attr_ff_hold_reset <= 1'b0;
            zws_en             <= 1'b0;
            palette_wr_exec    <= 1'b0;
        end else begin
            attr_ff_hold_reset <= ctrl_a_q[4:3] == ext_cfg_pkg::MAP_A0_AF;
            zws_en             <= isa_bus && mem_a_q[ext_cfg_pkg::MEMA_ZWS_EN];
            palette_wr_exec    <= cycle_valid && cycle_palette_wr;
        end
    end

    // ------------------------------------------------------------
    // bus claim: LDEV and MCS16
    // ------------------------------------------------------------
    // a shadowed palette write is left for the ISA side to see
    wire claim     = cycle_valid &&
                     !(cycle_palette_wr && pal_shadow_q);
    wire ldev_full = strap_q[ext_cfg_pkg::STRAP_LDEV_DECODE];
    wire la_hit    = la_hi == ext_cfg_pkg::COMPAT_LA_HIT;
    wire win_hit   = (graphics_misc_map == ext_cfg_pkg::MAP_A0_AF) ? !sa_mid[1] :
                     (graphics_misc_map == ext_cfg_pkg::MAP_B0_B7) ? (sa_mid == 2'b10) :
                     (graphics_misc_map == ext_cfg_pkg::MAP_B8_BF) ? (sa_mid == 2'b11) :
                     1'b1;
    wire compat    = la_hit && (!mem_a_q[ext_cfg_pkg::MEMA_MCS16_COMPAT] || win_hit);

    always_ff @(posedge clk) begin
        if (rst) begin
            ldev_n_out <= 1'b1;
            ldev_n_oe  <= 1'b0;
            mcs16_n    <= 1'b1;
        end else begin
            ldev_n_out <= ldev_full ? !claim : 1'b0;
            ldev_n_oe  <= ldev_full ? 1'b1 : (claim && cycle_first_t2);
            mcs16_n    <= !(linear_fb_hit || compat);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    index_bit7_zero_a: assert property (
        io_rvalid && $past(io_addr, 2) == ext_cfg_pkg::INDEX_PORT_ADDR
        |-> io_rdata[7] == 1'b0)
        else $error("index readback bit 7 not zero");

    version_read_a: assert property (
        io_rvalid && $past(hit_data, 2) && $past(index_q, 2) == 7'h00
        && $past(index_q, 1) == 7'h00
        |-> io_rdata == {CHIP_TYPE, CHIP_REV})
        else $error("version register read wrong");

    strap_capture_a: assert property (
        $fell(rst) |=> strap_q == $past(strap_s2_q))
        else $error("straps not captured at reset release");

    rdy_delay_a: assert property (
        strap_q[1:0] == 2'b11 && !strap_q[7] && !$past(rst) |=> rdy_hold_off)
        else $error("ready delay not applied");

    wide_reset_a: assert property (
        @(posedge clk) disable iff (1'b0) rst |=> !wide_regs_en)
        else $error("wide register enable survived reset");

    ctrl_write_a: assert property (
        wr_mem_a |=> cpu_fifo_en == $past(io_wdata[5])
        ##0 mem_config == $past(io_wdata[1:0]))
        else $error("memory control write not taken");

    zws_isa_only_a: assert property (
        !isa_bus |=> !zws_en)
        else $error("zero wait enabled outside isa");

    shadow_no_claim_a: assert property (
        cycle_valid && cycle_palette_wr && pal_shadow_q && !ldev_full
        |=> !ldev_n_oe)
        else $error("shadowed palette write claimed");

    linear_mcs16_a: assert property (
        linear_fb_hit |=> !mcs16_n)
        else $error("linear hit without mcs16");

    unmapped_write_a: assert property (
        wr_data && !is_stored && index_q > 7'h04
        |=> $stable(ctrl_a_q) && $stable(mem_a_q))
        else $error("unmapped write changed state");

    read_latency_a: assert property (
        io_rd && (hit_index || hit_data) |-> ##2 io_rvalid)
        else $error("read answer not two cycles later");

    cov_index_write_c:  cover property (wr_index ##1 wr_data);
    cov_stored_read_c:  cover property (rd_mem ##2 io_rvalid);
    cov_compat_win_c:   cover property (mem_a_q[3] && la_hit && win_hit);
    cov_ldev_first_c:   cover property (!ldev_full && claim && cycle_first_t2);

endmodule : extension_config_regs

`default_nettype wire

// ---- verif/host_io_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host bus controller issuing i/o cycles
// ----------------------------------------
module host_io_model (
    // host i/o port
    input  wire logic        clk,
    output var  logic [15:0] io_addr,
    output var  logic        io_wr,
    output var  logic        io_rd,
    output var  logic [7:0]  io_wdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rvalid
);
    // idle bus from time zero, so no unknown strobe reaches the block
    initial begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        // released lines must not keep the last value
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        io_addr <= ~a;
        repeat (4) begin
            @(posedge clk);
            if (!ok && io_rvalid === 1'b1) begin
                ok = 1'b1;
                d = io_rdata;
            end
        end
    endtask : rd
endmodule : host_io_model
`default_nettype wire

// ---- verif/extension_config_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// register bank bench
// ----------------------------------------
module extension_config_regs_test;
    localparam logic [3:0] TYPE_ID = 4'h6;  // arbitrary value
    logic clk = 1'b0, rst = 1'b1, io_wr, io_rd, io_rvalid;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, strap_bus_bits = 8'h98;
    logic attr_ff_is_data = 0, cycle_valid = 0, cycle_first_t2 = 0;
    logic cycle_palette_wr = 0, linear_fb_hit = 0;
    logic [6:0]  la_hi = 7'h00;
    logic [1:0]  sa_mid = 2'h0, graphics_misc_map = 2'h0, attr_map, mem_config;
    logic host_is_local, isa_hclk_half, clk_src_internal, isa_hclk_internal, rdy_hold_off;
    logic attr_ff_hold_reset, decode_low10, wide_regs_en, palette_wr_exec;
    logic addr_bit17_en, cpu_fifo_en, zws_en, ldev_n_out, ldev_n_oe, mcs16_n;
    int n_errors = 0, tests_run = 0, cycles = 0;

    always #12.5 clk = ~clk;

    host_io_model i_host_io_model (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

    extension_config_regs #(.CHIP_TYPE(TYPE_ID), .CHIP_REV(4'h0)) i_extension_config_regs (.*);

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wreg(input logic [6:0] idx, input logic [7:0] d);
        i_host_io_model.wr(ext_cfg_pkg::INDEX_PORT_ADDR, {1'b0, idx});
        i_host_io_model.wr(ext_cfg_pkg::DATA_PORT_ADDR, d);
        // registered side outputs follow the write by one more edge
        repeat (2) @(posedge clk);
        #1;
    endtask : wreg

    task automatic rx(input string nm, input logic [6:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_host_io_model.wr(ext_cfg_pkg::INDEX_PORT_ADDR, {1'b0, idx});
        i_host_io_model.rd(ext_cfg_pkg::DATA_PORT_ADDR, d, ok);
        chk(nm, ok ? d : ~exp, exp);
    endtask : rx

    // {attr, valid, t2, pal, fb, la[6:0], sa[1:0], map[1:0]}
    task automatic drv(input logic [15:0] v);
        @(posedge clk);
        {attr_ff_is_data, cycle_valid, cycle_first_t2, cycle_palette_wr, linear_fb_hit,
         la_hi, sa_mid, graphics_misc_map} <= v;
        repeat (2) @(posedge clk);
        #1;
    endtask : drv

    task automatic do_reset(input logic [7:0] s);
        @(posedge clk);
        strap_bus_bits <= s;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset

    wire [7:0] strap_out = {3'h0, host_is_local, isa_hclk_half, clk_src_internal,
                            isa_hclk_internal, rdy_hold_off};
    wire [7:0] claim_out = {4'h0, palette_wr_exec, ldev_n_out, ldev_n_oe, mcs16_n};
    wire [7:0] mem_out   = {3'h0, mem_config, addr_bit17_en, cpu_fifo_en, zws_en};

    initial begin
        do_reset(8'h98);
        rx("version", 7'h00, {TYPE_ID, 4'h0});
        wreg(7'h01, 8'h00);
        rx("straps", 7'h01, 8'h98);
        rx("io_base", 7'h07, 8'hF4);
        rx("mem_a", 7'h04, 8'h00);
        chk("strap_out", strap_out, 8'h0E);
        i_host_io_model.wr(ext_cfg_pkg::INDEX_PORT_ADDR, 8'h85);
        begin : idx_rd
            logic [7:0] d;
            logic ok;
            i_host_io_model.rd(ext_cfg_pkg::INDEX_PORT_ADDR, d, ok);
            chk("index", ok ? d : 8'hFF, 8'h05);
        end
        drv(16'h8000);
        wreg(7'h02, 8'hFF);
        rx("ctrl_a", 7'h02, 8'hB8);
        chk("if_out", {4'h0, attr_map, decode_low10, attr_ff_hold_reset}, 8'h0E);
        wreg(7'h02, 8'h08);
        chk("attr_hold", {4'h0, attr_map, decode_low10, attr_ff_hold_reset}, 8'h05);
        wreg(7'h03, 8'hFF);
        rx("ctrl_b", 7'h03, 8'h03);
        chk("wide_en", {7'h0, wide_regs_en}, 8'h01);
        wreg(7'h04, 8'hFF);
        rx("mem_a", 7'h04, 8'h6F);
        chk("mem_out", mem_out, 8'h1F);
        drv(16'h6051);
        chk("claim", claim_out, 8'h02);
        drv(16'h7059);
        chk("shadow", claim_out, 8'h09);
        drv(16'h0800);
        chk("linear", claim_out, 8'h00);
        wreg(7'h04, 8'h00);
        drv(16'h0059);
        chk("compat_hit", claim_out, 8'h00);
        drv(16'h0049);
        chk("compat_miss", claim_out, 8'h01);
        wreg(7'h12, 8'h5A);
        rx("hole", 7'h12, 8'h00);
        wreg(7'h0F, 8'h5A);
        rx("flags", 7'h0F, 8'h5A);
        do_reset(8'h43);
        chk("strap_out2", strap_out, 8'h11);
        rx("straps2", 7'h01, 8'h43);
        rx("keep", 7'h0F, 8'h5A);
        rx("ctrl_b2", 7'h03, 8'h01);
        wreg(7'h04, 8'h40);
        chk("zws_local", mem_out, 8'h00);
        drv(16'h0000);
        chk("ldev_idle", claim_out, 8'h07);
        drv(16'h4000);
        chk("ldev_dec", claim_out, 8'h03);
        stop_test();
    end
endmodule : extension_config_regs_test
`default_nettype wire
